//--- design/odt_output_tile.sv
// output data and tristate register tile with an AXI4-Lite config slave
// assumes fabric inputs on clk; set/reset inputs from fabric on clk
//
// Contract
// - data and tristate share clk, separate enables
// - each path set/reset loads its chosen value
// - each path: flop, dual-rate, latch or comb
// - comb mode passes input with no storage
// - dual-rate mux select comes from clock
// - falling capture uses inverted clock, one port
// - dual-edge mode samples both clock edges
// - rise data at rising, fall data at falling
// - single-edge mode takes both at rising edge
// - single-edge mode also on tristate path
// - edge select picks dual (default) or single
// - enable low holds registers, no new data (comb mode ignores it)
// - reverse reset clears dual-rate register
// - set input sets dual-rate register
// - power-up value 0 default or 1
// - set/reset sync (default) or async
`timescale 1ns/1ps
`default_nettype none
`include "odt_regs.svh"

module odt_output_tile (
   input wire logic clk, // system clock, 100 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic rise_data_in, // data for rising half
   input wire logic fall_data_in, // data for falling half
   input wire logic output_clock_enable, // data path enable
   input wire logic tri_rise_in, // tristate control, rising half
   input wire logic tri_fall_in, // tristate control, falling half
   input wire logic tristate_clock_enable, // tristate path enable
   input wire logic primary_set_reset, // loads the chosen value
   input wire logic reverse_set_reset, // clears the registers
   input wire logic set_input, // sets the registers
   output logic pad_data_out, // to pad driver data
   output logic pad_tristate_ctrl, // high releases the pad
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);

   ////////////////////////////////////////////////////////////////////////
   // register slave

   logic [`ODT_CFG_WIDTH-1:0] cfg_reg;
   logic initLoad_reg;
   logic awHeld_reg;
   logic wHeld_reg;
   logic [31:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic bValid_reg;
   logic [1:0] bResp_reg;
   logic rValid_reg;
   logic [31:0] rData_reg;
   logic [1:0] rResp_reg;

   wire doWrite = awHeld_reg & wHeld_reg;
   wire cfgWHit = awAddr_reg == `ODT_CFG_OFFSET;
   wire cmdWHit = awAddr_reg == `ODT_CMD_OFFSET;
   wire wMapped = cfgWHit | cmdWHit;
   wire cfgRHit = s_axi_araddr == `ODT_CFG_OFFSET;
   wire statRHit = s_axi_araddr == `ODT_STATUS_OFFSET;
   wire cmdRHit = s_axi_araddr == `ODT_CMD_OFFSET;
   wire rMapped = cfgRHit | statRHit | cmdRHit;
   wire arTake = s_axi_arvalid & s_axi_arready;

   assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
   assign s_axi_wready = ~wHeld_reg & ~bValid_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_arready = ~rValid_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 32'h0000_0000;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
         bValid_reg <= 1'b0;
         bResp_reg <= `ODT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg <= wMapped ? `ODT_RESP_OKAY : `ODT_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_reg <= 1'b0;
         end
      end
   end

   // config bits; writes steer the two path engines
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_reg <= `ODT_CFG_RESET;
      end else if (doWrite & cfgWHit) begin
         if (wStrb_reg[0]) begin
            cfg_reg[7:0] <= wData_reg[7:0];
         end
         if (wStrb_reg[1]) begin
            cfg_reg[`ODT_CFG_WIDTH-1:8] <= wData_reg[`ODT_CFG_WIDTH-1:8];
         end
      end
   end

   // writing the init bit reloads the power-up values
   always_ff @(posedge clk) begin
      if (rst) begin
         initLoad_reg <= 1'b0;
      end else begin
         initLoad_reg <= doWrite & cmdWHit & wStrb_reg[0] &
            wData_reg[`ODT_CMD_INIT_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // path decode

   odt_pkg::odt_path_cfg_t pathCfg [2];
   odt_pkg::odt_path_in_t pathIn [2];
   logic pathQ [2];
   logic pathRise [2];
   logic pathFall [2];

   wire srAsyncSel = cfg_reg[`ODT_CFG_RESET_SYNC_SELECT_BIT];
   wire srAny = primary_set_reset | reverse_set_reset | set_input;

   assign pathCfg[0] = '{
      mode: odt_pkg::odt_mode_t'(cfg_reg[`ODT_CFG_DMODE_LSB +: 2]),
      edgeSel: odt_pkg::odt_edge_t'(cfg_reg[`ODT_CFG_DEDGE_BIT]),
      reset_value_select: cfg_reg[`ODT_CFG_DSRVAL_BIT],
      initVal: cfg_reg[`ODT_CFG_DINIT_BIT]
   };
   assign pathCfg[1] = '{
      mode: odt_pkg::odt_mode_t'(cfg_reg[`ODT_CFG_TMODE_LSB +: 2]),
      edgeSel: odt_pkg::odt_edge_t'(cfg_reg[`ODT_CFG_TEDGE_BIT]),
      reset_value_select: cfg_reg[`ODT_CFG_TSRVAL_BIT],
      initVal: cfg_reg[`ODT_CFG_TINIT_BIT]
   };
   // one clock for both, each path its own enable
   assign pathIn[0] = '{
      riseD: rise_data_in,
      fallD: fall_data_in,
      ce: output_clock_enable
   };
   assign pathIn[1] = '{
      riseD: tri_rise_in,
      fallD: tri_fall_in,
      ce: tristate_clock_enable
   };

   ////////////////////////////////////////////////////////////////////////
   // path engines: index 0 data, index 1 tristate

   for (genvar p = 0; p < 2; p++) begin : gPath
      odt_pkg::odt_path_cfg_t c;
      odt_pkg::odt_path_in_t in;
      logic riseReg;
      logic heldReg;
      logic fallReg;
      logic latchReg;
      logic srValue;
      logic ddrQ;
      logic latchQ;
      logic modeQ;

      assign c = pathCfg[p];
      assign in = pathIn[p];
      // primary loads chosen value, then reverse clears, then set
      assign srValue = primary_set_reset ? c.reset_value_select :
         (reverse_set_reset ? 1'b0 : 1'b1);

      // rising half; set/reset outranks enable
      always_ff @(posedge clk) begin
         if (rst) begin
            riseReg <= `ODT_POWER_UP_VALUE;
            heldReg <= `ODT_POWER_UP_VALUE;
         end else if (initLoad_reg) begin
            riseReg <= c.initVal;
            heldReg <= c.initVal;
         end else if (srAny) begin
            riseReg <= srValue;
            heldReg <= srValue;
         end else if (in.ce) begin
            riseReg <= in.riseD;
            heldReg <= in.fallD;
         end
      end

      // falling half on the inverted clock
      always_ff @(negedge clk) begin
         if (rst) begin
            fallReg <= `ODT_POWER_UP_VALUE;
            latchReg <= `ODT_POWER_UP_VALUE;
         end else if (initLoad_reg) begin
            fallReg <= c.initVal;
            latchReg <= c.initVal;
         end else if (srAny) begin
            fallReg <= srValue;
            latchReg <= srValue;
         end else if (in.ce) begin
            fallReg <= (c.edgeSel == odt_pkg::EDGE_SINGLE) ?
               heldReg : in.fallD;
            latchReg <= in.riseD;
         end
      end

      // clock high shows rising data, low shows falling data
      assign ddrQ = clk ? riseReg : fallReg;
      assign latchQ = (clk & in.ce) ? in.riseD : latchReg;
      assign modeQ = (c.mode == odt_pkg::MODE_FLOP) ? riseReg :
         (c.mode == odt_pkg::MODE_DUAL) ? ddrQ :
         (c.mode == odt_pkg::MODE_LATCH) ? latchQ :
         in.riseD;
      // async type forces the stored value at once
      assign pathQ[p] = (srAny & srAsyncSel &
         (c.mode != odt_pkg::MODE_COMB)) ? srValue : modeQ;
      assign pathRise[p] = riseReg;
      assign pathFall[p] = fallReg;
   end

   assign pad_data_out = pathQ[0];
   assign pad_tristate_ctrl = pathQ[1];

   ////////////////////////////////////////////////////////////////////////
   // read side

   logic [31:0] statusWord;
   logic [31:0] readWord;

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`ODT_STAT_DQ_BIT] = pathQ[0];
      statusWord[`ODT_STAT_TQ_BIT] = pathQ[1];
      statusWord[`ODT_STAT_DRISE_BIT] = pathRise[0];
      statusWord[`ODT_STAT_DFALL_BIT] = pathFall[0];
      statusWord[`ODT_STAT_TRISE_BIT] = pathRise[1];
      statusWord[`ODT_STAT_TFALL_BIT] = pathFall[1];
   end

   assign readWord = cfgRHit ? {21'h000000, cfg_reg} :
      (statRHit ? statusWord : 32'h0000_0000);

   always_ff @(posedge clk) begin
      if (rst) begin
         rValid_reg <= 1'b0;
         rData_reg <= 32'h0000_0000;
         rResp_reg <= `ODT_RESP_OKAY;
      end else if (arTake) begin
         rValid_reg <= 1'b1;
         rData_reg <= readWord;
         rResp_reg <= rMapped ? `ODT_RESP_OKAY : `ODT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rValid_reg <= 1'b0;
      end
   end

endmodule

`default_nettype wire

//--- design/odt_regs.svh
// register offsets, field positions and reset values of the output tile
// assumes byte addressing with one aligned 32-bit word per register
`ifndef ODT_REGS_SVH
`define ODT_REGS_SVH

`define ODT_CFG_OFFSET 32'h0000_0000
`define ODT_STATUS_OFFSET 32'h0000_0004
`define ODT_CMD_OFFSET 32'h0000_0008

`define ODT_CFG_DMODE_LSB 0
`define ODT_CFG_TMODE_LSB 2
`define ODT_CFG_DEDGE_BIT 4
`define ODT_CFG_TEDGE_BIT 5
`define ODT_CFG_DSRVAL_BIT 6
`define ODT_CFG_TSRVAL_BIT 7
`define ODT_CFG_DINIT_BIT 8
`define ODT_CFG_TINIT_BIT 9
`define ODT_CFG_RESET_SYNC_SELECT_BIT 10
`define ODT_CFG_WIDTH 11
`define ODT_CFG_RESET 11'h000

`define ODT_CMD_INIT_BIT 0

`define ODT_STAT_DQ_BIT 0
`define ODT_STAT_TQ_BIT 1
`define ODT_STAT_DRISE_BIT 4
`define ODT_STAT_DFALL_BIT 5
`define ODT_STAT_TRISE_BIT 6
`define ODT_STAT_TFALL_BIT 7

`define ODT_POWER_UP_VALUE 1'b0

`define ODT_RESP_OKAY 2'b00
`define ODT_RESP_SLVERR 2'b10

`endif

//--- design/odt_pkg.sv
// types of the output tile: path modes, edge modes, path carriers
// assumes nothing beyond a SystemVerilog compiler
package odt_pkg;

   typedef enum logic [1:0] {
      MODE_FLOP  = 2'b00,
      MODE_DUAL  = 2'b01,
      MODE_LATCH = 2'b10,
      MODE_COMB  = 2'b11
   } odt_mode_t;

   typedef enum logic {
      EDGE_DUAL   = 1'b0,
      EDGE_SINGLE = 1'b1
   } odt_edge_t;

   typedef struct packed {
      odt_mode_t mode;
      odt_edge_t edgeSel;
      logic reset_value_select;
      logic initVal;
   } odt_path_cfg_t;

   typedef struct packed {
      logic riseD;
      logic fallD;
      logic ce;
   } odt_path_in_t;

endpackage

//--- verif/odt_fabric_model.sv
// fabric side model: data and tristate levels for the output tile
// assumes random bits and a forward request come from the bench
`timescale 1ns/1ps
`default_nettype none
module odt_fabric_model (
   input wire logic clk, // clock
   input wire logic fwd, // forward the clock
   input wire logic [3:0] rnd, // random levels
   output logic riseD, // rise data
   output logic fallD, // fall data
   output logic triR, // tristate rise
   output logic triF // tristate fall
);
   // both halves move together after the rising edge; one driver each
   always @(posedge clk) begin
      riseD <= fwd ? 1'b0 : rnd[0];
      fallD <= fwd ? 1'b1 : rnd[1];
      {triR, triF} <= rnd[3:2];
   end
endmodule
`default_nettype wire

//--- verif/odt_output_tile_monitor.sv
// pad checker for the output tile, bound to its ports
// assumes full-word config writes, inputs moved after rising edges
`timescale 1ns/1ps
`default_nettype none
module odt_output_tile_monitor (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic rise_data_in, // rise data
   input wire logic fall_data_in, // fall data
   input wire logic output_clock_enable, // data enable
   input wire logic primary_set_reset, // load value
   input wire logic reverse_set_reset, // clear
   input wire logic set_input, // set
   input wire logic pad_data_out, // pad data
   input wire logic pad_tristate_ctrl, // pad release
   input wire logic [31:0] s_axi_awaddr, // aw addr
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // w data
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready // w ready
);
   logic [10:0] cfg_reg;
   logic [1:0] awHist_reg;
   wire wrCfg = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr == 32'h0;
   wire [1:0] dm = cfg_reg[1:0];
   wire srAny = primary_set_reset || reverse_set_reset || set_input;
   wire dSr = primary_set_reset ? cfg_reg[6] : !reverse_set_reset;
   wire tSr = primary_set_reset ? cfg_reg[7] : !reverse_set_reset;
   wire okD = output_clock_enable && !srAny && !rst;
   // config and init loads land up to two edges after the offer
   wire still = !s_axi_awvalid && awHist_reg == 2'h0;
   wire calm = still && !cfg_reg[10];
   always_ff @(posedge clk) begin
      awHist_reg <= rst ? 2'h0 : {awHist_reg[0], s_axi_awvalid};
      cfg_reg <= rst ? 11'h000 : (wrCfg ? s_axi_wdata[10:0] : cfg_reg);
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   a_flop_capture: assert property (
      dm == 2'h0 && calm && okD |=> pad_data_out == $past(rise_data_in))
      else $error("flop missed rise data");
   a_hold_enable: assert property (
      dm == 2'h0 && calm && !output_clock_enable && !srAny
      |=> $stable(pad_data_out)) else $error("pad moved, enable low");
   a_dual_rise: assert property (@(negedge clk)
      dm == 2'h1 && calm && $past(okD) |-> pad_data_out == $past(rise_data_in))
      else $error("high half missed rise data");
   a_dual_fall: assert property (
      dm == 2'h1 && !cfg_reg[4] && calm && okD
      |-> pad_data_out == fall_data_in) else $error("low half wrong");
   a_single_fall: assert property (
      dm == 2'h1 && cfg_reg[4] && calm && okD && $past(okD)
      |-> pad_data_out == $past(fall_data_in)) else $error("held half wrong");
   a_comb_pass: assert property (
      dm == 2'h3 && still |-> pad_data_out == rise_data_in)
      else $error("comb path not direct");
   a_tri_setreset: assert property (
      cfg_reg[3:2] == 2'h0 && calm && srAny
      |=> pad_tristate_ctrl == $past(tSr)) else $error("tristate sr missed");
   a_async_force: assert property (
      cfg_reg[10] && still && dm != 2'h3 && srAny |-> pad_data_out == dSr)
      else $error("async sr not immediate");
   c_dual: cover property (dm == 2'h1 && !cfg_reg[4] && okD);
   c_single: cover property (dm == 2'h1 && cfg_reg[4] && okD);
   c_async: cover property (cfg_reg[10] && srAny);
endmodule
bind odt_output_tile odt_output_tile_monitor mon_u (.clk, .rst,
   .rise_data_in, .fall_data_in, .output_clock_enable, .primary_set_reset,
   .reverse_set_reset, .set_input, .pad_data_out, .pad_tristate_ctrl,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wvalid, .s_axi_wready);
`default_nettype wire

//--- verif/odt_output_tile_bench.sv
// bench for the output tile: bus map, init, forwarding, random modes
// assumes the fabric model, design and bound monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module odt_output_tile_bench;
   logic clk, rst, fwd, rise_data_in, fall_data_in, tri_rise_in, tri_fall_in;
   logic output_clock_enable, tristate_clock_enable, primary_set_reset;
   logic reverse_set_reset, set_input, pad_data_out, pad_tristate_ctrl;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb, rnd;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int fails, compares, seed, v;
   logic [10:0] cfgs [6] = '{11'h000, 11'h005, 11'h035, 11'h00f, 11'h0c0,
      11'h40a};
   odt_fabric_model fab_u (.clk, .fwd, .rnd, .riseD(rise_data_in),
      .fallD(fall_data_in), .triR(tri_rise_in), .triF(tri_fall_in));
   odt_output_tile dut_u (.clk, .rst, .rise_data_in, .fall_data_in,
      .output_clock_enable, .tri_rise_in, .tri_fall_in,
      .tristate_clock_enable, .primary_set_reset, .reverse_set_reset,
      .set_input, .pad_data_out, .pad_tristate_ctrl, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] statusOf(logic d, logic t);
      return {24'h0, {2{t}}, {2{d}}, 2'h0, t, d};
   endfunction
   task test_done;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // one bus transfer; rd picks read, d is write data or expected read
   task bus(input logic rd, input logic [31:0] a, d, input logic [1:0] er);
      logic tA, tW, tR, tB;
      @(posedge clk);
      {s_axi_araddr, s_axi_awaddr, s_axi_wdata} <= {a, a, d};
      {s_axi_arvalid, s_axi_rready} <= {2{rd}};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{!rd}};
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         tB = rd ? s_axi_rvalid && s_axi_rready : s_axi_bvalid && s_axi_bready;
         if (tB) begin
            chk("resp", {30'h0, er}, {30'h0, rd ? s_axi_rresp : s_axi_bresp});
            if (rd) chk("rdata", d, s_axi_rdata);
         end
         tA = s_axi_awvalid && s_axi_awready;
         tW = s_axi_wvalid && s_axi_wready;
         tR = s_axi_arvalid && s_axi_arready;
         @(posedge clk);
         if (tA) s_axi_awvalid <= 1'b0;
         if (tW) s_axi_wvalid <= 1'b0;
         if (tR) s_axi_arvalid <= 1'b0;
         if (tB) begin
            {s_axi_bready, s_axi_rready} <= 2'h0;
            return;
         end
      end
      fails++;
      test_done;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      seed = 46749;
      {rst, fwd, rnd, output_clock_enable, tristate_clock_enable} = 8'h80;
      {primary_set_reset, reverse_set_reset, set_input} = 3'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0f;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {fails, compares} = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1, 32'h0, 32'h0, 2'h0);
      bus(1, 32'h4, statusOf(0, 0), 2'h0);
      bus(0, 32'h4, 32'h0, 2'h2);
      bus(0, 32'hc, 32'h0, 2'h2);
      bus(1, 32'hc, 32'h0, 2'h2);
      bus(0, 32'h0, 32'h300, 2'h0);
      bus(1, 32'h0, 32'h300, 2'h0);
      bus(0, 32'h8, 32'h1, 2'h0);
      bus(1, 32'h4, statusOf(1, 1), 2'h0);
      bus(0, 32'h0, 32'h1, 2'h0);
      {fwd, output_clock_enable} <= 2'h3;
      repeat (3) @(posedge clk);
      #2 chk("fwd high", 32'h0, {31'h0, pad_data_out});
      @(negedge clk);
      #2 chk("fwd low", 32'h1, {31'h0, pad_data_out});
      bus(0, 32'h0, 32'h400, 2'h0);
      {fwd, output_clock_enable, set_input} <= 3'h1;
      #2 chk("async set", 32'h1, {31'h0, pad_data_out});
      @(posedge clk);
      {set_input, reverse_set_reset} <= 2'h1;
      #2 chk("async clear", 32'h0, {31'h0, pad_data_out});
      foreach (cfgs[i]) begin
         @(posedge clk);
         {primary_set_reset, reverse_set_reset, set_input} <= 3'h0;
         bus(0, 32'h0, {21'h0, cfgs[i]}, 2'h0);
         repeat (80) begin
            @(posedge clk);
            v = $random(seed);
            rnd <= v[3:0];
            output_clock_enable <= v[4] | v[5];
            tristate_clock_enable <= v[6];
            primary_set_reset <= v[9:7] == 3'h0;
            reverse_set_reset <= v[12:10] == 3'h0;
            set_input <= v[15:13] == 3'h0;
         end
      end
      test_done;
   end
endmodule
`default_nettype wire
